/* pkg/dfd_pkg.sv */
/*
  Constants shared by the duplicate frame detector and its id allocator.
  Assumes one 20 MHz clock and a synchronous active-low reset.
*/
package dfd_pkg;
  localparam int ADDR_W      = 7;
  localparam int ID_W        = 8;
  localparam int FCS_W       = 32;
  localparam int OCT_W       = 16;
  localparam int DCNT_W      = 4;
  localparam int RCNT_W      = 3;
  localparam int DEPTH       = 16;
  localparam int IDX_W       = 4;
  localparam int NUM_IDS     = 256;
  localparam int MAX_PER_SRC = 255;
  localparam logic [RCNT_W-1:0] RX_LIMIT   = 3'h7;
  localparam logic [RCNT_W-1:0] RCNT_FIRST = 3'h1;
  localparam logic [ID_W-1:0]   ID_RST     = 8'h00;
  localparam logic [IDX_W-1:0]  WPTR_RST   = 4'h0;
endpackage

/* design/dfd_id_alloc.sv */
/*
  Originator id allocator: hands out identification numbers that are not
  currently outstanding and frees them on acknowledgement.
  Assumes requests and acks are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps
module dfd_id_alloc
  import dfd_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            alloc_req,
  input  wire logic            ack_valid,
  input  wire logic [ID_W-1:0] ack_id,
  output logic                 alloc_valid,
  output logic [ID_W-1:0]      alloc_id
);
  logic [NUM_IDS-1:0] busy;
  logic [NUM_IDS-1:0] next_busy;
  logic [ID_W-1:0]    cand;
  logic [ID_W-1:0]    next_cand;
  logic               pend;
  logic               next_pend;
  logic               next_alloc_valid;
  logic [ID_W-1:0]    next_alloc_id;
  logic               want;

  assign want = pend | alloc_req;

  // ==========================================================
  // Allocation
  always_comb begin
    next_busy        = busy;
    next_cand        = cand;
    next_pend        = want;
    next_alloc_valid = 1'b0;
    next_alloc_id    = alloc_id;
    if (ack_valid) begin
      next_busy[ack_id] = 1'b0;
    end
    if (!busy[cand]) begin
      if (want) begin
        // Grant tests registered busy, so an id freed by an ack goes out a cycle later at the earliest; the set after the ack clear wins
        next_busy[cand]  = 1'b1;
        next_alloc_valid = 1'b1;
        next_alloc_id    = cand;
        next_pend        = 1'b0;
        next_cand        = cand + 8'h01;
      end
    end else begin
      // Keep scanning so a free id is ready before the next request
      next_cand = cand + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy        <= '0;
      cand        <= ID_RST;
      pend        <= 1'b0;
      alloc_valid <= 1'b0;
      alloc_id    <= ID_RST;
    end else begin
      busy        <= next_busy;
      cand        <= next_cand;
      pend        <= next_pend;
      alloc_valid <= next_alloc_valid;
      alloc_id    <= next_alloc_id;
    end
  end

  // ==========================================================
  // Checks
  grant_free_a: assert property (@(posedge clk) disable iff (!rst_n)
    want && !busy[cand] |=> alloc_valid && alloc_id == $past(cand))
    else $error("free candidate not granted");
  grant_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    alloc_valid |-> busy[alloc_id])
    else $error("granted id not held outstanding");
endmodule

/* design/dfd_detector.sv */
/*
  Duplicate detection for received acknowledged-information commands, with
  the originator id allocator alongside.
  Assumes frame fields arrive parsed and FCS-checked in one cycle pulse.
*/
`timescale 1ns/1ps
module dfd_detector
  import dfd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              acked_info_command,
  input  wire logic [ADDR_W-1:0] rx_src,
  input  wire logic [ADDR_W-1:0] rx_dst,
  input  wire logic [ID_W-1:0]   rx_id,
  input  wire logic [FCS_W-1:0]  rx_fcs,
  input  wire logic [OCT_W-1:0]  rx_octets,
  input  wire logic [DCNT_W-1:0] rx_dcount,
  input  wire logic              network_join_message,
  input  wire logic              network_leave_message,
  input  wire logic [ADDR_W-1:0] station_addr,
  input  wire logic              tx_id_req,
  input  wire logic              tx_ack_valid,
  input  wire logic [ID_W-1:0]   tx_ack_id,
  output logic                   res_valid,
  output logic                   res_dup,
  output logic                   res_deliver,
  output logic                   tx_id_valid,
  output logic [ID_W-1:0]        tx_id
);
  // ==========================================================
  // History table
  logic [DEPTH-1:0]  v;
  logic [ADDR_W-1:0] h_src [DEPTH];
  logic [ADDR_W-1:0] h_dst [DEPTH];
  logic [ID_W-1:0]   h_id [DEPTH];
  logic [FCS_W-1:0]  h_fcs [DEPTH];
  logic [OCT_W-1:0]  h_oct [DEPTH];
  logic [DCNT_W-1:0] h_dcnt [DEPTH];
  logic [RCNT_W-1:0] h_rcnt [DEPTH];
  logic [IDX_W-1:0]  wptr;

  logic [DEPTH-1:0]  next_v;
  logic [ADDR_W-1:0] next_src [DEPTH];
  logic [ADDR_W-1:0] next_dst [DEPTH];
  logic [ID_W-1:0]   next_id [DEPTH];
  logic [FCS_W-1:0]  next_fcs [DEPTH];
  logic [OCT_W-1:0]  next_oct [DEPTH];
  logic [DCNT_W-1:0] next_dcnt [DEPTH];
  logic [RCNT_W-1:0] next_rcnt [DEPTH];
  logic [IDX_W-1:0]  next_wptr;
  logic              next_res_valid;
  logic              next_res_dup;
  logic              next_res_deliver;

  logic              purge;
  logic [DEPTH-1:0]  purge_hit;
  logic [DEPTH-1:0]  src_hit;
  logic [DEPTH-1:0]  hit;
  logic              any_hit;
  logic [IDX_W-1:0]  hidx;
  logic [RCNT_W-1:0] hit_rcnt;
  logic              is_dup;
  logic [8:0]        src_cnt;

  assign purge = network_join_message | network_leave_message;

  // ==========================================================
  // Parallel compare
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      assign purge_hit[g] = purge && v[g] && h_src[g] == station_addr;
      // A join or leave in the same cycle empties the sender first
      assign src_hit[g] = v[g] && !purge_hit[g] && h_src[g] == rx_src;
      assign hit[g]     = src_hit[g] && h_id[g] == rx_id;
    end
  endgenerate

  always_comb begin
    any_hit = 1'b0;
    hidx    = '0;
    src_cnt = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        hidx    = IDX_W'(i);
      end
      src_cnt = src_cnt + {8'h00, src_hit[i]};
    end
    hit_rcnt = h_rcnt[hidx];
    // Duplicate test: same octets, under the receive limit, and lower dcount or same dcount and FCS; a miss means non-duplicate
    is_dup = any_hit && h_oct[hidx] == rx_octets && hit_rcnt < RX_LIMIT
             && (rx_dcount < h_dcnt[hidx]
                 || (rx_dcount == h_dcnt[hidx] && rx_fcs == h_fcs[hidx]));
  end

  // ==========================================================
  // Table update and verdict
  always_comb begin
    next_v           = v & ~purge_hit;
    next_src         = h_src;
    next_dst         = h_dst;
    next_id          = h_id;
    next_fcs         = h_fcs;
    next_oct         = h_oct;
    next_dcnt        = h_dcnt;
    next_rcnt        = h_rcnt;
    next_wptr        = wptr;
    next_res_valid   = acked_info_command;
    next_res_dup     = 1'b0;
    next_res_deliver = 1'b0;
    if (acked_info_command) begin
      if (is_dup) begin
        next_rcnt[hidx] = hit_rcnt + RCNT_FIRST;
        next_res_dup    = 1'b1;
      end else begin
        if (any_hit) begin
          next_v = next_v & ~src_hit;
        end
        next_res_deliver = 1'b1;
        // Ring insertion: wptr always names the oldest slot, so a full
        // table evicts the oldest entry; purged holes age out with it
        next_v[wptr]    = 1'b1;
        next_src[wptr]  = rx_src;
        next_dst[wptr]  = rx_dst;
        next_id[wptr]   = rx_id;
        next_fcs[wptr]  = rx_fcs;
        next_oct[wptr]  = rx_octets;
        next_dcnt[wptr] = rx_dcount;
        next_rcnt[wptr] = RCNT_FIRST;
        next_wptr       = wptr + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v           <= '0;
      wptr        <= WPTR_RST;
      res_valid   <= 1'b0;
      res_dup     <= 1'b0;
      res_deliver <= 1'b0;
    end else begin
      v           <= next_v;
      wptr        <= next_wptr;
      res_valid   <= next_res_valid;
      res_dup     <= next_res_dup;
      res_deliver <= next_res_deliver;
    end
  end

  // Payload fields need no reset; valid bits guard them
  always_ff @(posedge clk) begin
    h_src  <= next_src;
    h_dst  <= next_dst;
    h_id   <= next_id;
    h_fcs  <= next_fcs;
    h_oct  <= next_oct;
    h_dcnt <= next_dcnt;
    h_rcnt <= next_rcnt;
  end

  // ==========================================================
  // Originator ids
  dfd_id_alloc u_dfd_id_alloc (
    .clk         (clk),
    .rst_n       (rst_n),
    .alloc_req   (tx_id_req),
    .ack_valid   (tx_ack_valid),
    .ack_id      (tx_ack_id),
    .alloc_valid (tx_id_valid),
    .alloc_id    (tx_id)
  );

  // ==========================================================
  // Checks
  nondup_verdict_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && !any_hit |=> res_valid && !res_dup && res_deliver)
    else $error("unmatched frame not passed as new");
  dup_verdict_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command |=> res_valid && res_dup == $past(is_dup))
    else $error("duplicate verdict wrong");
  rx_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && any_hit && hit_rcnt == RX_LIMIT |=> !res_dup)
    else $error("frame seen seven times called duplicate");
  count_bump_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && is_dup |=> h_rcnt[$past(hidx)] == $past(hit_rcnt) + RCNT_FIRST && !res_deliver)
    else $error("duplicate count not bumped");
  insert_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && !is_dup |=> v[$past(wptr)] && h_rcnt[$past(wptr)] == RCNT_FIRST
                                      && h_id[$past(wptr)] == $past(rx_id))
    else $error("new frame not recorded");
  mismatch_purge_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && any_hit && !is_dup
    |=> v == (($past(v) & ~$past(src_hit) & ~$past(purge_hit)) | (DEPTH'(1) << $past(wptr))))
    else $error("sender history kept after mismatch");
  entry_fields_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && !is_dup
    |=> h_src[$past(wptr)] == $past(rx_src) && h_dst[$past(wptr)] == $past(rx_dst)
        && h_fcs[$past(wptr)] == $past(rx_fcs) && h_oct[$past(wptr)] == $past(rx_octets)
        && h_dcnt[$past(wptr)] == $past(rx_dcount))
    else $error("new entry fields not stored");
  // Only new frames move the ring; a duplicate must not age the table
  ring_advance_a: assert property (@(posedge clk) disable iff (!rst_n)
    acked_info_command && !is_dup |=> wptr == $past(wptr) + 4'h1)
    else $error("ring pointer not advanced on insert");
  deliver_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    res_deliver == (res_valid && !res_dup))
    else $error("delivery flag disagrees with verdict");
  join_purge_a: assert property (@(posedge clk) disable iff (!rst_n)
    purge && !acked_info_command |=> (v & $past(purge_hit)) == '0)
    else $error("join or leave did not purge sender");
  sender_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    src_cnt <= MAX_PER_SRC)
    else $error("sender history over limit");

  dup_seen_c:    cover property (@(posedge clk) disable iff (!rst_n) res_valid && res_dup);
  mismatch_c:    cover property (@(posedge clk) disable iff (!rst_n) acked_info_command && any_hit && !is_dup);
  join_purge_c:  cover property (@(posedge clk) disable iff (!rst_n) purge && |purge_hit);
  wrap_c:        cover property (@(posedge clk) disable iff (!rst_n) acked_info_command && !is_dup && &v);
  seventh_c:     cover property (@(posedge clk) disable iff (!rst_n) acked_info_command && any_hit
                                 && hit_rcnt == RX_LIMIT);
endmodule

/* test/dfd_station_model.sv */
/*
  Remote station model: hands received acked-info command fields and
  join/leave messages to the detector, one cycle per frame or message.
  Assumes clk is the detector clock; outputs change only at rising edges.
*/
`timescale 1ns/1ps
module dfd_station_model
  import dfd_pkg::*;
(
  input  wire logic           clk,
  output logic                acked_info_command,
  output logic [ADDR_W-1:0]   rx_src,
  output logic [ADDR_W-1:0]   rx_dst,
  output logic [ID_W-1:0]     rx_id,
  output logic [FCS_W-1:0]    rx_fcs,
  output logic [OCT_W-1:0]    rx_octets,
  output logic [DCNT_W-1:0]   rx_dcount,
  output logic                network_join_message,
  output logic                network_leave_message,
  output logic [ADDR_W-1:0]   station_addr
);
  initial begin
    {acked_info_command, network_join_message, network_leave_message} = 3'h0;
    {rx_src, rx_dst, rx_id, rx_fcs, rx_octets, rx_dcount, station_addr} = '0;
  end

  // ==========================================================
  // Frame and message transfers
  task automatic frame(input logic [ADDR_W-1:0] src, input logic [ID_W-1:0] id,
                       input logic [FCS_W-1:0] fcs, input logic [OCT_W-1:0] oct,
                       input logic [DCNT_W-1:0] dc);
    @(posedge clk);
    acked_info_command <= 1'b1;
    {rx_src, rx_dst, rx_id, rx_fcs, rx_octets, rx_dcount} <= {src, 7'h05, id, fcs, oct, dc};
    @(posedge clk);
    acked_info_command <= 1'b0;
    // Stale fields flipped so a design reading them late sees garbage
    {rx_src, rx_dst, rx_id, rx_fcs, rx_octets, rx_dcount} <= ~{src, 7'h05, id, fcs, oct, dc};
  endtask

  task automatic msg(input logic leave, input logic [ADDR_W-1:0] src);
    @(posedge clk);
    network_join_message  <= !leave;
    network_leave_message <= leave;
    station_addr          <= src;
    @(posedge clk);
    {network_join_message, network_leave_message} <= 2'h0;
    station_addr <= ~src;
  endtask
endmodule

/* test/dfd_detector_tb.sv */
/*
  Self-checking bench for the duplicate frame detector and id allocator.
  Assumes the station model drives the frame side; bench drives id requests.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module dfd_detector_tb;
  import dfd_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              tx_id_req = 1'b0;
  logic              tx_ack_valid = 1'b0;
  logic [ID_W-1:0]   tx_ack_id = 8'h00;
  logic              aic, jn, lv, res_valid, res_dup, res_deliver, tx_id_valid;
  logic [ADDR_W-1:0] src, dst, sta;
  logic [ID_W-1:0]   id, tx_id, id_a, id_b;
  logic [FCS_W-1:0]  fcs;
  logic [OCT_W-1:0]  oct;
  logic [DCNT_W-1:0] dc;
  int                num_errors = 0;
  int                compares = 0;

  always #25 clk = ~clk;

  dfd_station_model u_dfd_station_model (.clk(clk), .acked_info_command(aic), .rx_src(src), .rx_dst(dst),
    .rx_id(id), .rx_fcs(fcs), .rx_octets(oct), .rx_dcount(dc), .network_join_message(jn),
    .network_leave_message(lv), .station_addr(sta));

  dfd_detector u_dfd_detector (.clk(clk), .rst_n(rst_n), .acked_info_command(aic), .rx_src(src),
    .rx_dst(dst), .rx_id(id), .rx_fcs(fcs), .rx_octets(oct), .rx_dcount(dc), .network_join_message(jn),
    .network_leave_message(lv), .station_addr(sta), .tx_id_req(tx_id_req), .tx_ack_valid(tx_ack_valid),
    .tx_ack_id(tx_ack_id), .res_valid(res_valid), .res_dup(res_dup), .res_deliver(res_deliver),
    .tx_id_valid(tx_id_valid), .tx_id(tx_id));

  // ==========================================================
  // Shared transfers
  task automatic fr(input logic [ADDR_W-1:0] s, input logic [ID_W-1:0] i, input logic [FCS_W-1:0] f,
                    input logic [OCT_W-1:0] o, input logic [DCNT_W-1:0] d, input logic dup);
    u_dfd_station_model.frame(s, i, f, o, d);
    #1;
    `CHK(res_valid, 1'b1)
    `CHK(res_dup, dup)
    `CHK(res_deliver, !dup)
  endtask

  task automatic get_id(output logic [ID_W-1:0] v);
    @(posedge clk);
    tx_id_req <= 1'b1;
    @(posedge clk);
    tx_id_req <= 1'b0;
    #1;
    for (int n = 0; n < 300 && tx_id_valid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(tx_id_valid, 1'b1)
    v = tx_id;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_rules();
    fr(7'h01, 8'h0A, 32'hAAAA0001, 16'h0014, 4'h3, 1'b0);
    fr(7'h01, 8'h0A, 32'hAAAA0001, 16'h0014, 4'h3, 1'b1);
    fr(7'h01, 8'h0A, 32'hBBBB0002, 16'h0014, 4'h2, 1'b1);
    fr(7'h01, 8'h0A, 32'hAAAA0001, 16'h0014, 4'h4, 1'b0);
    fr(7'h01, 8'h0A, 32'hAAAA0001, 16'h0014, 4'h4, 1'b1);
    fr(7'h01, 8'h0A, 32'hCCCC0003, 16'h0014, 4'h4, 1'b0);
    $display("test rules done");
  endtask

  task automatic t_purge();
    fr(7'h05, 8'h15, 32'h00000015, 16'h0008, 4'h1, 1'b0);
    fr(7'h02, 8'h15, 32'h00000015, 16'h0008, 4'h1, 1'b0);
    fr(7'h02, 8'h14, 32'h00000014, 16'h0008, 4'h1, 1'b0);
    fr(7'h02, 8'h14, 32'h00000014, 16'h0009, 4'h1, 1'b0);
    fr(7'h02, 8'h15, 32'h00000015, 16'h0008, 4'h1, 1'b0);
    fr(7'h05, 8'h15, 32'h00000015, 16'h0008, 4'h1, 1'b1);
    $display("test purge done");
  endtask

  task automatic t_seven();
    fr(7'h03, 8'h1E, 32'h1234ABCD, 16'h0100, 4'h2, 1'b0);
    for (int k = 0; k < 6; k++) begin
      fr(7'h03, 8'h1E, 32'h1234ABCD, 16'h0100, 4'h2, 1'b1);
    end
    fr(7'h03, 8'h1E, 32'h1234ABCD, 16'h0100, 4'h2, 1'b0);
    $display("test seven done");
  endtask

  task automatic t_join();
    fr(7'h04, 8'h28, 32'h0000FFFF, 16'h0002, 4'h1, 1'b0);
    fr(7'h04, 8'h29, 32'h0000FFFF, 16'h0002, 4'h1, 1'b0);
    u_dfd_station_model.msg(1'b0, 7'h04);
    fr(7'h04, 8'h28, 32'h0000FFFF, 16'h0002, 4'h1, 1'b0);
    u_dfd_station_model.msg(1'b1, 7'h04);
    fr(7'h04, 8'h28, 32'h0000FFFF, 16'h0002, 4'h1, 1'b0);
    $display("test join done");
  endtask

  // Sixteen new ids from one sender fill the ring; one more evicts the oldest
  task automatic t_wrap();
    for (int k = 0; k < 16; k++) begin
      fr(7'h06, 8'h40 + 8'(k), 32'h00000040, 16'h0004, 4'h1, 1'b0);
    end
    fr(7'h06, 8'h40, 32'h00000040, 16'h0004, 4'h1, 1'b1);
    fr(7'h06, 8'h50, 32'h00000050, 16'h0004, 4'h1, 1'b0);
    fr(7'h06, 8'h40, 32'h00000040, 16'h0004, 4'h1, 1'b0);
    $display("test wrap done");
  endtask

  task automatic t_ids();
    get_id(id_a);
    get_id(id_b);
    `CHK(id_b !== id_a, 1'b1)
    @(posedge clk);
    tx_ack_valid <= 1'b1;
    tx_ack_id    <= id_a;
    @(posedge clk);
    tx_ack_valid <= 1'b0;
    get_id(id_a);
    `CHK(id_a !== id_b, 1'b1)
    $display("test ids done");
  endtask

  // ==========================================================
  // Run control
  task automatic end_sim();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_rules();
    t_purge();
    t_seven();
    t_join();
    t_wrap();
    t_ids();
    end_sim();
  end

  // Whole run is well under 300 cycles; generous margin
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
